// ### cbt_timer.sv
`timescale 1ns/1ps
// Behaviour
// - event mode counts falling edges on input
// - lower and upper halves form one counter
// - counting starts when run bit written 1
// - event match raises irq, clears counter
// - after match, counting resumes from zero
// - period compare takes effect immediately
// - pwm counts internal or external clock
// - duty match toggles flop, counting continues
// - overflow toggles flop, clears, raises irq
// - flop loads initial level, resets to zero
// - pwm pin drives inverse of flop
// - duty buffered, moved at pwm overflow or stopped
// - duty read returns active shifted value
// - stop holds pin; later write sets level
// - control codes select clock and mode
module cbt_timer
   import cbt_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // control byte writes
   input wire logic i_lower_timer_control_wr,
   input wire logic [7:0] i_lower_timer_control,
   input wire logic i_upper_timer_control_wr,
   input wire logic [7:0] i_upper_timer_control,
   // compare byte writes, sharing one data byte
   input wire logic i_period_compare_low_wr,
   input wire logic i_period_compare_high_wr,
   input wire logic i_duty_compare_low_wr,
   input wire logic i_duty_compare_high_wr,
   input wire logic [7:0] i_wr_data,
   // clock environment
   input wire logic i_divider_source_select,
   input wire logic i_low_speed_mode,
   input wire logic i_low_freq_clock,
   // pins
   input wire logic i_event_input_pin,
   output logic o_pwm_output_pin,
   // status and read-back
   output logic o_cascade_match_irq,
   output logic o_running,
   output logic [15:0] o_counter,
   output logic [15:0] o_period_compare,
   output logic [15:0] o_duty_compare,
   output logic [7:0] o_lower_timer_control,
   output logic [7:0] o_upper_timer_control
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   cbt_tick_if tick ();

   logic [7:0] lower_ctrl;
   logic [7:0] upper_ctrl;
   logic [7:0] next_lower_ctrl;
   logic [7:0] next_upper_ctrl;
   logic [15:0] period_cmp;
   logic [15:0] next_period_cmp;
   // writes land in the buffer; only the active copy meets the counter
   logic [15:0] duty_buf;
   logic [15:0] next_duty_buf;
   logic [15:0] duty_act;
   logic [15:0] next_duty_act;
   logic [15:0] count;
   logic [15:0] next_count;
   logic [15:0] count_inc;
   logic flop;
   logic next_flop;
   logic next_irq;
   logic running;
   logic event_fall;
   logic low_freq_edge;
   cbt_mode_type mode;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and source clock selection

   cbt_edge_sync u_event_sync
   (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_pin(i_event_input_pin),
      .o_fall(event_fall),
      .o_rise()
   );

   cbt_edge_sync u_low_freq_sync
   (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_pin(i_low_freq_clock),
      .o_fall(),
      .o_rise(low_freq_edge)
   );

   // lower control byte picks the source for the whole pair
   assign tick.src_sel = lower_ctrl[CBT_SEL_MSB:CBT_SEL_LSB];
   assign tick.divider_source_select = i_divider_source_select;
   assign tick.low_speed = i_low_speed_mode;
   assign tick.low_freq_edge = low_freq_edge;
   assign tick.event_fall = event_fall;

   cbt_prescaler u_prescaler
   (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .tick(tick.prescaler)
   );

   ////////////////////////////////////////////////////////////////////////////
   // mode decode from both control bytes

   assign running = upper_ctrl[CBT_RUN_BIT];

   // only the cascaded codes run; event mode needs the external source
   // upper count code with an internal source would be timer mode, not built
   always_comb
   begin
      mode = CBT_OFF;
      if (lower_ctrl[CBT_MODE_MSB:CBT_MODE_LSB] == CBT_LOWER_MODE_16)
      begin
         if (upper_ctrl[CBT_MODE_MSB:CBT_MODE_LSB] == CBT_UPPER_MODE_PWM)
         begin
            mode = CBT_PWM;
         end
         else if ((upper_ctrl[CBT_MODE_MSB:CBT_MODE_LSB] == CBT_UPPER_MODE_COUNT) &&
            (lower_ctrl[CBT_SEL_MSB:CBT_SEL_LSB] == CBT_SEL_EXTERNAL))
         begin
            mode = CBT_EVENT;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control and compare byte registers

   // byte-wide writes land as given; pairing is up to software
   always_comb
   begin
      next_lower_ctrl = lower_ctrl;
      next_upper_ctrl = upper_ctrl;
      next_period_cmp = period_cmp;
      next_duty_buf = duty_buf;
      if (i_lower_timer_control_wr)
      begin
         next_lower_ctrl = i_lower_timer_control;
      end
      if (i_upper_timer_control_wr)
      begin
         next_upper_ctrl = i_upper_timer_control;
      end
      // unbuffered: the compare sees the new byte at once
      if (i_period_compare_low_wr)
      begin
         next_period_cmp[7:0] = i_wr_data;
      end
      if (i_period_compare_high_wr)
      begin
         next_period_cmp[15:8] = i_wr_data;
      end
      if (i_duty_compare_low_wr)
      begin
         next_duty_buf[7:0] = i_wr_data;
      end
      if (i_duty_compare_high_wr)
      begin
         next_duty_buf[15:8] = i_wr_data;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         lower_ctrl <= CBT_CTRL_RESET;
         upper_ctrl <= CBT_CTRL_RESET;
         period_cmp <= CBT_WORD_RESET;
         duty_buf <= CBT_WORD_RESET;
      end
      else
      begin
         lower_ctrl <= next_lower_ctrl;
         upper_ctrl <= next_upper_ctrl;
         period_cmp <= next_period_cmp;
         duty_buf <= next_duty_buf;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // 16-bit counter, output flop and duty transfer

   assign count_inc = count + CBT_WORD_ONE;

   always_comb
   begin
      next_count = count;
      next_flop = flop;
      next_duty_act = duty_act;
      next_irq = 1'b0;
      if (!running)
      begin
         // stopped: counter parks at zero, flop holds its level
         next_count = CBT_WORD_RESET;
         next_duty_act = duty_buf;
         // a control write while already stopped reloads the level;
         // the write that stops the timer does not touch it
         if (i_upper_timer_control_wr)
         begin
            next_flop = i_upper_timer_control[CBT_FF_BIT];
         end
      end
      else if (tick.count_tick)
      begin
         unique case (mode)
            CBT_EVENT:
            begin
               // clear in the same tick that reaches the period value
               // a zero period matches only once the counter wraps
               if (count_inc == period_cmp)
               begin
                  next_count = CBT_WORD_RESET;
                  next_irq = 1'b1;
               end
               else
               begin
                  next_count = count_inc;
               end
            end
            CBT_PWM:
            begin
               // overflow ends the period; a zero duty never matches,
               // so such a period shows only the overflow edge
               if (count == CBT_WORD_MAX)
               begin
                  next_count = CBT_WORD_RESET;
                  next_flop = ~flop;
                  next_irq = 1'b1;
                  // old buffer wins over a write landing in this cycle
                  next_duty_act = duty_buf;
               end
               else
               begin
                  next_count = count_inc;
                  if (count_inc == duty_act)
                  begin
                     next_flop = ~flop;
                  end
               end
            end
            CBT_OFF:
            begin
               next_count = count;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         count <= CBT_WORD_RESET;
         flop <= 1'b0;
         duty_act <= CBT_WORD_RESET;
         o_cascade_match_irq <= 1'b0;
      end
      else
      begin
         count <= next_count;
         flop <= next_flop;
         duty_act <= next_duty_act;
         o_cascade_match_irq <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // pin is the inverse of the flop, so reset leaves it high
   assign o_pwm_output_pin = ~flop;
   assign o_running = running;
   assign o_counter = count;
   assign o_period_compare = period_cmp;
   // reads show the active compare, not the pending buffer
   // so a write while running in pwm mode reads back old until the next overflow
   assign o_duty_compare = duty_act;
   assign o_lower_timer_control = lower_ctrl;
   assign o_upper_timer_control = upper_ctrl;

endmodule

// ### cbt_pkg.sv
package cbt_pkg;

   // control byte field positions
   localparam int CBT_FF_BIT = 7;
   localparam int CBT_SEL_MSB = 6;
   localparam int CBT_SEL_LSB = 4;
   localparam int CBT_RUN_BIT = 3;
   localparam int CBT_MODE_MSB = 2;
   localparam int CBT_MODE_LSB = 0;

   // reset values
   localparam logic [7:0] CBT_CTRL_RESET = 8'h00;
   localparam logic [15:0] CBT_WORD_RESET = 16'h0000;
   localparam logic [15:0] CBT_WORD_MAX = 16'hFFFF;
   localparam logic [15:0] CBT_WORD_ONE = 16'h0001;

   // mode field encodings
   localparam logic [2:0] CBT_LOWER_MODE_16 = 3'h3;
   localparam logic [2:0] CBT_UPPER_MODE_COUNT = 3'h4;
   localparam logic [2:0] CBT_UPPER_MODE_PWM = 3'h6;

   // source clock select encodings
   localparam logic [2:0] CBT_SEL_DIV11 = 3'h0;
   localparam logic [2:0] CBT_SEL_DIV7 = 3'h1;
   localparam logic [2:0] CBT_SEL_DIV5 = 3'h2;
   localparam logic [2:0] CBT_SEL_DIV3 = 3'h3;
   localparam logic [2:0] CBT_SEL_LOW_FREQ = 3'h4;
   localparam logic [2:0] CBT_SEL_DIV1 = 3'h5;
   localparam logic [2:0] CBT_SEL_HIGH_FREQ = 3'h6;
   localparam logic [2:0] CBT_SEL_EXTERNAL = 3'h7;

   // prescaler widths
   localparam int CBT_DIV_W = 11;
   localparam logic [2:0] CBT_LOW_DIV_LAST = 3'h7;

   // operating modes of the cascaded pair
   typedef enum logic [2:0]
   {
      CBT_OFF = 3'b001,
      CBT_EVENT = 3'b010,
      CBT_PWM = 3'b100
   } cbt_mode_type;

endpackage

// ### cbt_tick_if.sv
`timescale 1ns/1ps
interface cbt_tick_if;
   logic [2:0] src_sel;
   logic divider_source_select;
   logic low_speed;
   logic low_freq_edge;
   logic event_fall;
   logic count_tick;

   modport prescaler
   (
      input src_sel,
      input divider_source_select,
      input low_speed,
      input low_freq_edge,
      input event_fall,
      output count_tick
   );

   modport core
   (
      output src_sel,
      output divider_source_select,
      output low_speed,
      output low_freq_edge,
      output event_fall,
      input count_tick
   );
endinterface

// ### cbt_edge_sync.sv
`timescale 1ns/1ps
module cbt_edge_sync
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // asynchronous pin
   input wire logic i_pin,
   // one-cycle edge pulses
   output logic o_fall,
   output logic o_rise
);

   logic sync1;
   logic sync2;
   logic sync3;
   logic level;
   logic next_level;
   logic next_fall;
   logic next_rise;

   // a change counts only once stages two and three agree
   always_comb
   begin
      next_level = level;
      next_fall = 1'b0;
      next_rise = 1'b0;
      if (sync2 == sync3)
      begin
         next_level = sync3;
         next_fall = level & ~sync3;
         next_rise = ~level & sync3;
      end
   end

   // first stage is read only by the second
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         sync3 <= 1'b1;
         level <= 1'b1;
         o_fall <= 1'b0;
         o_rise <= 1'b0;
      end
      else
      begin
         sync1 <= i_pin;
         sync2 <= sync1;
         sync3 <= sync2;
         level <= next_level;
         o_fall <= next_fall;
         o_rise <= next_rise;
      end
   end

endmodule

// ### cbt_prescaler.sv
`timescale 1ns/1ps
module cbt_prescaler
   import cbt_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // selection and tick
   cbt_tick_if.prescaler tick
);

   logic [CBT_DIV_W-1:0] div;
   logic [CBT_DIV_W-1:0] next_div;
   logic [2:0] low_div;
   logic [2:0] next_low_div;
   logic next_tick;
   logic low_tick;

   // free-running divider of the reference clock, the fast source
   always_comb
   begin
      next_div = div + {{(CBT_DIV_W-1){1'b0}}, 1'b1};
      next_low_div = low_div;
      if (tick.low_freq_edge)
      begin
         next_low_div = low_div + 3'h1;
      end
      low_tick = tick.low_freq_edge && (low_div == CBT_LOW_DIV_LAST);
      next_tick = 1'b0;
      // the slow-speed modes only allow the two low-frequency sources and the external pin
      unique case (tick.src_sel)
         CBT_SEL_DIV11: next_tick = tick.divider_source_select || tick.low_speed ?
            low_tick : (&div[10:0]);
         CBT_SEL_DIV7: next_tick = !tick.low_speed && (&div[6:0]);
         CBT_SEL_DIV5: next_tick = !tick.low_speed && (&div[4:0]);
         CBT_SEL_DIV3: next_tick = !tick.low_speed && (&div[2:0]);
         CBT_SEL_LOW_FREQ: next_tick = tick.low_freq_edge;
         CBT_SEL_DIV1: next_tick = !tick.low_speed && div[0];
         CBT_SEL_HIGH_FREQ: next_tick = !tick.low_speed;
         CBT_SEL_EXTERNAL: next_tick = tick.event_fall;
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         div <= '0;
         low_div <= 3'h0;
         tick.count_tick <= 1'b0;
      end
      else
      begin
         div <= next_div;
         low_div <= next_low_div;
         tick.count_tick <= next_tick;
      end
   end

endmodule

// ### cbt_timer_asserts.sv
`timescale 1ns/1ps
module cbt_timer_asserts
   import cbt_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // writes
   input wire logic i_upper_timer_control_wr,
   input wire logic [7:0] i_upper_timer_control,
   input wire logic i_period_compare_low_wr,
   input wire logic i_duty_compare_low_wr,
   input wire logic [7:0] i_wr_data,
   // observed outputs
   input wire logic o_pwm_output_pin,
   input wire logic o_cascade_match_irq,
   input wire logic o_running,
   input wire logic [15:0] o_counter,
   input wire logic [15:0] o_period_compare,
   input wire logic [15:0] o_duty_compare,
   input wire logic [7:0] o_upper_timer_control
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   logic pwm;
   // mode decode, so the irq checks split into event and pwm cases
   assign pwm = o_upper_timer_control[2:0] == CBT_UPPER_MODE_PWM;
   reset_pin_a: assert property (
      disable iff (1'b0) !i_reset_n |=> o_pwm_output_pin) else $error("pin low after reset");
   count_step_a: assert property (
      o_running && $past(o_running) && $changed(o_counter) && !o_cascade_match_irq
      |-> o_counter == $past(o_counter) + CBT_WORD_ONE) else $error("counter skipped");
   irq_clear_a: assert property (
      o_cascade_match_irq |-> o_counter == CBT_WORD_RESET && o_running)
      else $error("irq without clear");
   event_match_a: assert property (
      o_cascade_match_irq && !pwm |-> $past(o_counter) + CBT_WORD_ONE == o_period_compare)
      else $error("irq off period");
   pwm_wrap_a: assert property (
      o_cascade_match_irq && pwm |-> $past(o_counter) == CBT_WORD_MAX
      && $changed(o_pwm_output_pin)) else $error("pwm irq not at overflow");
   toggle_cause_a: assert property (
      $changed(o_pwm_output_pin) && $past(o_running)
      |-> o_cascade_match_irq || o_counter == o_duty_compare) else $error("stray toggle");
   stop_clear_a: assert property (
      !o_running |=> o_counter == CBT_WORD_RESET) else $error("counts while stopped");
   // reset reloads the flop, so the edge right after release is left out
   stop_hold_a: assert property (
      !o_running && !$past(o_running) && !$past(i_upper_timer_control_wr) && $past(i_reset_n)
      |-> $stable(o_pwm_output_pin)) else $error("pin moved while stopped");
   flop_load_a: assert property (
      i_upper_timer_control_wr && !o_running
      |=> o_pwm_output_pin != $past(i_upper_timer_control[CBT_FF_BIT]))
      else $error("flop not loaded");
   period_now_a: assert property (
      i_period_compare_low_wr |=> o_period_compare[7:0] == $past(i_wr_data))
      else $error("period not immediate");
   duty_stop_a: assert property (
      i_duty_compare_low_wr && !o_running && !i_upper_timer_control_wr
      |=> ##1 o_duty_compare[7:0] == $past(i_wr_data, 2)) else $error("duty not moved");
endmodule
bind cbt_timer cbt_timer_asserts i_chk (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
   .i_upper_timer_control_wr(i_upper_timer_control_wr),
   .i_upper_timer_control(i_upper_timer_control),
   .i_period_compare_low_wr(i_period_compare_low_wr),
   .i_duty_compare_low_wr(i_duty_compare_low_wr), .i_wr_data(i_wr_data),
   .o_pwm_output_pin(o_pwm_output_pin), .o_cascade_match_irq(o_cascade_match_irq),
   .o_running(o_running), .o_counter(o_counter), .o_period_compare(o_period_compare),
   .o_duty_compare(o_duty_compare), .o_upper_timer_control(o_upper_timer_control));

// ### cbt_pulse_src.sv
`timescale 1ns/1ps
module cbt_pulse_src
(
   // clock
   input wire logic i_ref_clk,
   // request
   input wire logic i_go,
   input wire logic [7:0] i_pulses,
   // pin side
   output logic o_event_pin,
   output logic o_busy
);
   logic [7:0] left = 8'h00;
   logic [2:0] hold = 3'h0;
   // idles high, as a pulled-up line would
   initial o_event_pin = 1'b1;
   assign o_busy = left != 8'h00;
   // eight cycles per level, well above the two machine cycle minimum
   always @(posedge i_ref_clk)
   begin
      if (i_go)
         left <= i_pulses;
      else if (o_busy)
      begin
         hold <= hold + 3'h1;
         if (hold == 3'h7)
         begin
            o_event_pin <= ~o_event_pin;
            if (!o_event_pin)
               left <= left - 8'h01;
         end
      end
   end
endmodule

// ### cascaded_16bit_event_pwm_timer_test.sv
`timescale 1ns/1ps
module cascaded_16bit_event_pwm_timer_test;
   import cbt_pkg::*;
   typedef struct {logic run; logic [15:0] per; logic [7:0] n; logic [15:0] cnt; int irqs;}
      cbt_row_type;
   typedef struct {logic [2:0] sel; logic slow; logic dv; logic [15:0] ticks;} cbt_src_type;
   logic i_ref_clk;
   logic i_reset_n;
   logic [5:0] wr;
   logic [7:0] d;
   logic go, pin, busy, o_pin, irq, run, slow, dv, lf;
   logic [7:0] n, lctl, uctl;
   logic [15:0] cnt, per, duty, base;
   int n_errors, compares, n_irq, i, r;
   // period and pulse count beside the count and irqs they should leave
   cbt_row_type rows [6] = '{'{1'b0, 16'h0003, 8'h02, 16'h0000, 0},
      '{1'b1, 16'h0005, 8'h03, 16'h0003, 0}, '{1'b1, 16'h0003, 8'h03, 16'h0000, 1},
      '{1'b1, 16'h0002, 8'h05, 16'h0001, 2}, '{1'b1, 16'h0001, 8'h02, 16'h0000, 2},
      '{1'b1, 16'h0103, 8'h04, 16'h0004, 0}};
   // source select and speed inputs beside the ticks expected in 512 cycles
   cbt_src_type srcs [8] = '{'{3'h3, 1'b0, 1'b0, 16'h0040}, '{3'h1, 1'b0, 1'b0, 16'h0004},
      '{3'h2, 1'b0, 1'b0, 16'h0010}, '{3'h5, 1'b0, 1'b0, 16'h0100},
      '{3'h4, 1'b0, 1'b0, 16'h0040}, '{3'h0, 1'b0, 1'b1, 16'h0008},
      '{3'h0, 1'b1, 1'b0, 16'h0008}, '{3'h6, 1'b1, 1'b0, 16'h0000}};
   ////////////////////////////////////////////////////////////////
   cbt_timer i_dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
      .i_lower_timer_control_wr(wr[0]), .i_lower_timer_control(d),
      .i_upper_timer_control_wr(wr[1]), .i_upper_timer_control(d),
      .i_period_compare_low_wr(wr[2]), .i_period_compare_high_wr(wr[3]),
      .i_duty_compare_low_wr(wr[4]), .i_duty_compare_high_wr(wr[5]), .i_wr_data(d),
      .i_divider_source_select(dv), .i_low_speed_mode(slow), .i_low_freq_clock(lf),
      .i_event_input_pin(pin), .o_pwm_output_pin(o_pin), .o_cascade_match_irq(irq),
      .o_running(run), .o_counter(cnt), .o_period_compare(per), .o_duty_compare(duty),
      .o_lower_timer_control(lctl), .o_upper_timer_control(uctl));
   cbt_pulse_src i_src (.i_ref_clk(i_ref_clk), .i_go(go), .i_pulses(n),
      .o_event_pin(pin), .o_busy(busy));
   ////////////////////////////////////////////////////////////////
   // clock, irq tally and watchdog
   initial
   begin
      i_ref_clk = 1'b0;
      forever #2 i_ref_clk = ~i_ref_clk;
   end
   // slow clock pin, eight reference cycles per period, moved on falling edges
   always #16 lf = ~lf;
   always @(posedge i_ref_clk) if (irq === 1'b1) n_irq++;
   initial
   begin
      #400000;
      n_errors++;
      stop_test();
   end
   ////////////////////////////////////////////////////////////////
   // idle cycle after each strobe, so a strobe is never set and cleared at once
   task automatic put(input int k, input logic [7:0] v);
      d = v;
      wr[k] = 1'b1;
      @(negedge i_ref_clk);
      wr = 6'h00;
      @(negedge i_ref_clk);
   endtask
   task automatic word(input int k, input logic [15:0] v);
      put(k, v[7:0]);
      put(k + 1, v[15:8]);
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      {wr, d, go, n, i_reset_n, slow, dv, lf, n_errors, compares, n_irq} = '0;
      repeat (3) @(negedge i_ref_clk);
      i_reset_n = 1'b1;
      chk({15'h0000, o_pin}, 16'h0001);
      chk(cnt | {lctl, uctl}, 16'h0000);
      $display("reset test done");
      for (r = 0; r < 6; r++)
      begin
         put(1, 8'h04);
         put(0, 8'h73);
         word(2, rows[r].per);
         chk(per, rows[r].per);
         put(1, {4'h0, rows[r].run, 3'h4});
         n_irq = 0;
         n = rows[r].n;
         go = 1'b1;
         @(negedge i_ref_clk);
         go = 1'b0;
         for (i = 0; busy && i < 500; i++) @(negedge i_ref_clk);
         chk({15'h0000, busy}, 16'h0000);
         repeat (8) @(negedge i_ref_clk);
         chk(cnt, rows[r].cnt);
         chk(16'(n_irq), 16'(rows[r].irqs));
         $display("event row %0d done", r);
      end
      put(1, 8'h56);
      put(0, 8'h33);
      chk({8'h00, lctl}, 16'h0033);
      put(0, 8'h63);
      word(4, 16'h0002);
      chk(duty, 16'h0002);
      put(1, 8'h5E);
      chk({15'h0000, run}, 16'h0001);
      chk({8'h00, uctl}, 16'h005E);
      for (i = 0; o_pin && i < 20; i++) @(negedge i_ref_clk);
      chk(cnt, 16'h0002);
      word(4, 16'h0005);
      chk(duty, 16'h0002);
      for (i = 0; !irq && i < 70000; i++) @(negedge i_ref_clk);
      chk({cnt[15:1], o_pin}, 16'h0001);
      chk(duty, 16'h0005);
      put(1, 8'h56);
      chk({cnt[15:1], o_pin}, 16'h0001);
      // each source counted over a whole number of its tick periods
      for (r = 0; r < 8; r++)
      begin
         put(1, 8'h56);
         put(0, {1'b0, srcs[r].sel, 4'h3});
         slow = srcs[r].slow;
         dv = srcs[r].dv;
         put(1, 8'h5E);
         base = cnt;
         repeat (512) @(negedge i_ref_clk);
         chk(cnt - base, srcs[r].ticks);
         $display("source row %0d done", r);
      end
      slow = 1'b0;
      dv = 1'b0;
      put(1, 8'h56);
      put(1, 8'hD6);
      chk({15'h0000, o_pin}, 16'h0000);
      put(4, 8'h07);
      @(negedge i_ref_clk);
      chk(duty, 16'h0007);
      i_reset_n = 1'b0;
      @(negedge i_ref_clk);
      i_reset_n = 1'b1;
      chk({15'h0000, o_pin}, 16'h0001);
      chk(cnt | {lctl, uctl}, 16'h0000);
      $display("pwm test done");
      stop_test();
   end
endmodule
